// >>> src/smbus_temp_readout_standby.sv
// top of the temperature readout: register file, standby control, result capture
//
// Behaviour
// - standby halts autoconversion
// - low standby pin enters hardware standby
// - config bit 6 set enters software standby
// - standby keeps registers and bus alive
// - one-shot in software standby runs one sequence
// - one-shot ignored in hardware standby
// - standby pin overrides every conversion request
// - standby mid-conversion aborts, results kept
// - byte-wide registers behind one slave address
// - write, read, send, receive byte supported
// - receive byte returns last pointed register
// - main temperatures at 00h and 01h
// - two's complement, 1 degree LSB, msb first
// - fractions at 10h, 11h when slow
// - main and fraction update together
// - busy flag high while converting
// - rate resets to 16Hz, fractions invalid
// - halt bit clear runs autoconversion
// - fraction in top three bits
`timescale 1ns/100ps
`include "smbus_temp_defines.svh"
module smbus_temp_readout_standby #(
  parameter int CONV_CYCLES = `CONV_CYCLES,
  parameter int SLOW_PERIOD = `SLOW_PERIOD_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        standby_pin_n,
  input  wire logic [10:0] local_temp_in,
  input  wire logic [10:0] remote_temp_in,
  output logic             busy
);
  import smbus_temp_pkg::*;

  top_regs_t    r, next_r;
  smbus_link_if link ();
  logic         conv_done;
  logic         hw_standby_pin_n;
  logic         cfg_halt;
  logic         hw_standby_pin_n_enter;
  logic         halt_set;
  logic         abort;
  logic         oneshot_req;
  logic         oneshot_go;
  logic         run_en;
  logic         ext_ok;
  logic [3:0]   rate_code;

  // ----------------------------------------------------------------
  // bus engine
  // ----------------------------------------------------------------
  // the bit engine is never gated by standby, so commands keep working
  smbus_bit_slave u_slave (
    .clk    (clk),
    .rst    (rst),
    .scl_in (scl_in),
    .sda_in (sda_in),
    .sda_oe (sda_oe),
    .link   (link)
  );

  // ----------------------------------------------------------------
  // conversion timebase
  // ----------------------------------------------------------------
  conv_sequencer #(
    .CONV_CYCLES (CONV_CYCLES),
    .SLOW_PERIOD (SLOW_PERIOD)
  ) u_conv (
    .clk       (clk),
    .rst       (rst),
    .run_en    (run_en),
    .oneshot   (oneshot_go),
    .abort     (abort),
    .rate_code (rate_code),
    .busy      (busy),
    .done      (conv_done)
  );

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  function automatic logic [7:0] reg_read(input top_regs_t s, input logic busy_now);
    logic [7:0] v;
    v = 8'h00;
    case (s.cmd_ptr)
      `CMD_LOCAL_MAIN:  v = s.local_main;
      `CMD_REMOTE_MAIN: v = s.remote_main;
      `CMD_STATUS:      v[`STATUS_BUSY_BIT] = busy_now;
      `CMD_CONFIG_RD:   v = s.cfg;
      `CMD_RATE_RD:     v = s.rate;
      `CMD_REMOTE_FRAC: v = s.remote_frac;
      `CMD_LOCAL_FRAC:  v = s.local_frac;
      default:          v = 8'h00;
    endcase
    return v;
  endfunction : reg_read

  // pointer persists across frames, so a bare receive byte reuses it
  assign link.tx_data = reg_read(r, busy);

  // ----------------------------------------------------------------
  // standby and conversion control
  // ----------------------------------------------------------------
  always_comb begin
    hw_standby_pin_n       = ~r.standby_pin_n_s2;
    cfg_halt      = r.cfg[`CFG_HALT_BIT];
    hw_standby_pin_n_enter = r.standby_pin_n_d & ~r.standby_pin_n_s2;
    halt_set      = link.rx_valid && !link.rx_first && r.cmd_ptr == `CMD_CONFIG_WR
                    && link.rx_data[`CFG_HALT_BIT] && !cfg_halt;
    abort         = hw_standby_pin_n_enter | halt_set;
    oneshot_req   = link.rx_valid && link.rx_first && link.rx_data == `CMD_ONE_SHOT;
    oneshot_go    = oneshot_req && !hw_standby_pin_n;
    run_en        = !cfg_halt && !hw_standby_pin_n;
    rate_code     = (r.rate > `RATE_MAX) ? 4'(`RATE_MAX) : r.rate[3:0];
    ext_ok        = r.rate <= `RATE_EXT_MAX;
  end

  // ----------------------------------------------------------------
  // state update
  // ----------------------------------------------------------------
  always_comb begin
    next_r         = r;
    next_r.standby_pin_n_s1 = standby_pin_n;
    next_r.standby_pin_n_s2 = r.standby_pin_n_s1;
    next_r.standby_pin_n_d  = r.standby_pin_n_s2;
    if (link.rx_valid) begin
      if (link.rx_first) begin
        next_r.cmd_ptr = link.rx_data;
      end else begin
        case (r.cmd_ptr)
          `CMD_CONFIG_WR: next_r.cfg  = link.rx_data;
          `CMD_RATE_WR:   next_r.rate = link.rx_data;
          default:        next_r.cfg  = r.cfg;
        endcase
      end
    end
    if (conv_done) begin
      // main and fraction of both channels change in the same cycle
      next_r.local_main  = local_temp_in[10:3];
      next_r.remote_main = remote_temp_in[10:3];
      // fast rates leave no time for the fine bits, report zero
      next_r.local_frac  = ext_ok ? {local_temp_in[2:0], `FRAC_PAD} : `TEMP_RESET;
      next_r.remote_frac = ext_ok ? {remote_temp_in[2:0], `FRAC_PAD} : `TEMP_RESET;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r             <= '0;
      r.standby_pin_n_s1     <= 1'b1;
      r.standby_pin_n_s2     <= 1'b1;
      r.standby_pin_n_d      <= 1'b1;
      r.cfg         <= `CONFIG_RESET;
      r.rate        <= `RATE_RESET;
      r.local_main  <= `TEMP_RESET;
      r.remote_main <= `TEMP_RESET;
      r.local_frac  <= `TEMP_RESET;
      r.remote_frac <= `TEMP_RESET;
    end else begin
      r <= next_r;
    end
  end

  // open-drain data pin only ever pulls low
  assign sda_out = r.sda_o;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_hw_held;
    hw_standby_pin_n [*2];
  endsequence

  sequence s_conv_start;
    !busy ##1 busy;
  endsequence

  sequence s_halt_idle;
    cfg_halt && !busy && !oneshot_go;
  endsequence

  sequence s_data_byte;
    link.rx_valid && !link.rx_first;
  endsequence

  sequence s_cmd_byte;
    link.rx_valid && link.rx_first;
  endsequence

  AST_HW_STANDBY_PIN_N_IDLE: assert property (s_hw_held |-> !busy)
    else $error("converting during hardware standby");

  AST_HALT_NO_AUTO: assert property (s_halt_idle |=> !busy)
    else $error("autoconversion while halted");

  AST_ONESHOT_SW: assert property (oneshot_go && !busy && !abort |=> busy)
    else $error("one-shot did not start a sequence");

  AST_ONESHOT_HW: assert property (s_hw_held ##0 oneshot_req |=> !busy)
    else $error("one-shot accepted in hardware standby");

  AST_PIN_PRIORITY: assert property (hw_standby_pin_n && !cfg_halt |=> !$rose(busy))
    else $error("run mode started despite standby pin");

  AST_ABORT: assert property (abort && busy |=> !busy && !conv_done)
    else $error("standby did not abort conversion");

  AST_HOLD_RESULTS: assert property (!conv_done |=> $stable(r.local_main) && $stable(r.remote_frac))
    else $error("results changed without a completed sequence");

  AST_PTR_STORE: assert property (link.rx_valid && link.rx_first |=> r.cmd_ptr == $past(link.rx_data))
    else $error("command pointer not stored");

  AST_MAIN_CAPTURE: assert property (conv_done |=> r.local_main == $past(local_temp_in[10:3]))
    else $error("main byte not captured");

  AST_FRAC_FAST_ZERO: assert property (conv_done && !ext_ok |=> r.local_frac == 8'h00)
    else $error("fraction reported at fast rate");

  AST_FRAC_TOGETHER: assert property (conv_done && ext_ok |=>
      r.remote_frac[7:5] == $past(remote_temp_in[2:0]) && r.remote_main == $past(remote_temp_in[10:3]))
    else $error("main and fraction not updated together");

  // a standby request may legally cut a sequence short, so only unaborted ones count
  AST_BUSY_WINDOW: assert property (s_conv_start ##0 !abort [*7] |=> busy)
    else $error("busy dropped early");

  AST_FRAC_LOW: assert property (r.local_frac[4:0] == 5'h00 && r.remote_frac[4:0] == 5'h00)
    else $error("fraction low bits not zero");

  AST_RESUME: assert property ($fell(cfg_halt) && !hw_standby_pin_n && !busy |-> ##[1:2] busy)
    else $error("autoconversion did not resume");

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------

  AST_CFG_WRITE: assert property (s_data_byte ##0 (r.cmd_ptr == `CMD_CONFIG_WR) |=> r.cfg == $past(link.rx_data))
    else $error("config byte not stored");

  AST_RATE_WRITE: assert property (s_data_byte ##0 (r.cmd_ptr == `CMD_RATE_WR) |=> r.rate == $past(link.rx_data))
    else $error("rate byte not stored");

  AST_HALT_SET: assert property (halt_set |=> cfg_halt && !busy)
    else $error("halt write did not stop conversions");

  AST_RO_WRITE: assert property (s_data_byte ##0
      (r.cmd_ptr == `CMD_LOCAL_MAIN && !conv_done) |=> $stable(r.local_main))
    else $error("read-only byte was written");

  AST_HW_PTR: assert property (s_cmd_byte ##0 hw_standby_pin_n |=> r.cmd_ptr == $past(link.rx_data))
    else $error("bus dead in hardware standby");

  AST_HW_KEEP: assert property (hw_standby_pin_n && !link.rx_valid && !conv_done |=>
      $stable(r.cfg) && $stable(r.local_main))
    else $error("register lost in hardware standby");

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------

  AST_READ_LOCAL: assert property (r.cmd_ptr == `CMD_LOCAL_MAIN |-> link.tx_data == r.local_main)
    else $error("local main byte not on read path");

  AST_READ_REMOTE: assert property (r.cmd_ptr == `CMD_REMOTE_MAIN |-> link.tx_data == r.remote_main)
    else $error("remote main byte not on read path");

  AST_READ_LFRAC: assert property (r.cmd_ptr == `CMD_LOCAL_FRAC |-> link.tx_data == r.local_frac)
    else $error("local fraction not on read path");

  AST_READ_RFRAC: assert property (r.cmd_ptr == `CMD_REMOTE_FRAC |-> link.tx_data == r.remote_frac)
    else $error("remote fraction not on read path");

  AST_STATUS_BUSY: assert property (r.cmd_ptr == `CMD_STATUS |-> link.tx_data == {busy, 7'h00})
    else $error("status does not show busy");

  // ----------------------------------------------------------------
  // sequencer control
  // ----------------------------------------------------------------

  AST_HW_ABORT: assert property (hw_standby_pin_n_enter |=> !busy)
    else $error("pin standby did not stop conversion");

  AST_RUN_START: assert property ($rose(run_en) && !busy && !abort |=> busy)
    else $error("run mode did not start a sequence");

  AST_DONE_AFTER_BUSY: assert property (conv_done |-> !busy && $past(busy))
    else $error("done without a busy sequence");

  AST_PIN_NO_ONESHOT: assert property (hw_standby_pin_n |-> !oneshot_go)
    else $error("one-shot passed the standby pin");

  AST_ONESHOT_HALTED: assert property (s_cmd_byte ##0
      (link.rx_data == `CMD_ONE_SHOT && cfg_halt && !hw_standby_pin_n && !busy) |=> busy)
    else $error("one-shot ignored in software standby");

  AST_LOCAL_FRAC: assert property (conv_done && ext_ok |=>
      r.local_frac[7:5] == $past(local_temp_in[2:0]))
    else $error("local fraction not captured");

endmodule : smbus_temp_readout_standby

// >>> src/smbus_temp_defines.svh
// command codes, field positions, reset values and timing counts of the readout block
`ifndef SMBUS_TEMP_DEFINES_SVH
`define SMBUS_TEMP_DEFINES_SVH

// value is arbitrary, pick per board
`define SLAVE_ADDR        7'h2a

`define CMD_LOCAL_MAIN    8'h00
`define CMD_REMOTE_MAIN   8'h01
`define CMD_STATUS        8'h02
`define CMD_CONFIG_RD     8'h03
`define CMD_RATE_RD       8'h04
`define CMD_CONFIG_WR     8'h09
`define CMD_RATE_WR       8'h0a
`define CMD_ONE_SHOT      8'h0f
`define CMD_REMOTE_FRAC   8'h10
`define CMD_LOCAL_FRAC    8'h11

`define CFG_HALT_BIT      6
`define STATUS_BUSY_BIT   7
`define CONFIG_RESET      8'h20
`define RATE_RESET        8'h08
`define RATE_MAX          8'h08
`define RATE_EXT_MAX      8'h06
`define TEMP_RESET        8'h00
`define FRAC_PAD          5'h00

`define CLK_FREQ_HZ       50000000
`define CONV_TIME_US      120000
`define CONV_CYCLES       ((`CONV_TIME_US) * (`CLK_FREQ_HZ / 1000000))
`define SLOW_PERIOD_MS    16000
`define SLOW_PERIOD_CYCLES ((`SLOW_PERIOD_MS) * (`CLK_FREQ_HZ / 1000))

`endif

// >>> src/smbus_temp_pkg.sv
// types shared by the readout block modules
package smbus_temp_pkg;

  typedef enum logic [6:0] {
    SL_IDLE     = 7'h01,
    SL_ADDR     = 7'h02,
    SL_ACK_ADDR = 7'h04,
    SL_RX       = 7'h08,
    SL_ACK_RX   = 7'h10,
    SL_TX       = 7'h20,
    SL_ACK_TX   = 7'h40
  } slave_state_t;

  typedef struct packed {
    logic         scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
    slave_state_t st;
    logic [3:0]   bitcnt;
    logic [7:0]   shreg;
    logic         oe, rw, first, rx_valid, rx_first, tx_load;
  } slave_regs_t;

  typedef struct packed {
    logic        busy, done;
    logic [31:0] cnt, per;
  } conv_regs_t;

  typedef struct packed {
    logic       standby_pin_n_s1, standby_pin_n_s2, standby_pin_n_d;
    logic [7:0] cmd_ptr, cfg, rate;
    logic [7:0] local_main, remote_main, local_frac, remote_frac;
    logic       sda_o;
  } top_regs_t;

endpackage : smbus_temp_pkg

// >>> src/smbus_link_if.sv
// byte-level link between the bit engine and the register file
`timescale 1ns/100ps
interface smbus_link_if;
  logic       rx_valid;
  logic       rx_first;
  logic [7:0] rx_data;
  logic [7:0] tx_data;
  logic       tx_load;

  modport slave (output rx_valid, rx_first, rx_data, tx_load, input tx_data);
  modport regs  (input rx_valid, rx_first, rx_data, tx_load, output tx_data);
endinterface : smbus_link_if

// >>> src/smbus_bit_slave.sv
// two-wire bit engine: start/stop, address match, byte shift, acknowledge
`timescale 1ns/100ps
`include "smbus_temp_defines.svh"
module smbus_bit_slave (
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire logic      scl_in,
  input  wire logic      sda_in,
  output logic           sda_oe,
  smbus_link_if.slave    link
);
  import smbus_temp_pkg::*;

  slave_regs_t r, next_r;
  logic        scl_rise, scl_fall, start_seen, stop_seen;

  always_comb begin
    scl_rise   = r.scl_s2 & ~r.scl_d;
    scl_fall   = ~r.scl_s2 & r.scl_d;
    start_seen = r.scl_s2 & r.scl_d & r.sda_d & ~r.sda_s2;
    stop_seen  = r.scl_s2 & r.scl_d & ~r.sda_d & r.sda_s2;
    next_r          = r;
    next_r.scl_s1   = scl_in;
    next_r.scl_s2   = r.scl_s1;
    next_r.scl_d    = r.scl_s2;
    next_r.sda_s1   = sda_in;
    next_r.sda_s2   = r.sda_s1;
    next_r.sda_d    = r.sda_s2;
    next_r.rx_valid = 1'b0;
    next_r.tx_load  = 1'b0;
    if (start_seen) begin
      next_r.st     = SL_ADDR;
      next_r.bitcnt = 4'h0;
      next_r.oe     = 1'b0;
      next_r.first  = 1'b1;
    end else if (stop_seen) begin
      next_r.st = SL_IDLE;
      next_r.oe = 1'b0;
    end else begin
      case (r.st)
        SL_ADDR, SL_RX: begin
          if (scl_rise && r.bitcnt != 4'h8) begin
            next_r.shreg  = {r.shreg[6:0], r.sda_s2};
            next_r.bitcnt = 4'(r.bitcnt + 4'h1);
          end
          if (scl_fall && r.bitcnt == 4'h8) begin
            if (r.st == SL_RX) begin
              next_r.oe       = 1'b1;
              next_r.st       = SL_ACK_RX;
              next_r.rx_valid = 1'b1;
              next_r.rx_first = r.first;
              next_r.first    = 1'b0;
            end else if (r.shreg[7:1] == `SLAVE_ADDR) begin
              next_r.oe = 1'b1;
              next_r.rw = r.shreg[0];
              next_r.st = SL_ACK_ADDR;
            end else begin
              next_r.st = SL_IDLE;
            end
          end
        end
        SL_ACK_ADDR: begin
          if (scl_fall) begin
            next_r.bitcnt = 4'h0;
            if (r.rw) begin
              next_r.shreg   = link.tx_data;
              next_r.oe      = ~link.tx_data[7];
              next_r.tx_load = 1'b1;
              next_r.st      = SL_TX;
            end else begin
              next_r.oe = 1'b0;
              next_r.st = SL_RX;
            end
          end
        end
        SL_ACK_RX: begin
          if (scl_fall) begin
            next_r.oe     = 1'b0;
            next_r.bitcnt = 4'h0;
            next_r.st     = SL_RX;
          end
        end
        SL_TX: begin
          if (scl_rise) next_r.bitcnt = 4'(r.bitcnt + 4'h1);
          if (scl_fall) begin
            if (r.bitcnt == 4'h8) begin
              next_r.oe = 1'b0;
              next_r.st = SL_ACK_TX;
            end else begin
              next_r.shreg = {r.shreg[6:0], 1'b0};
              next_r.oe    = ~r.shreg[6];
            end
          end
        end
        SL_ACK_TX: begin
          // master ack reloads the pointed register for another byte
          if (scl_rise) next_r.st = r.sda_s2 ? SL_IDLE : SL_ACK_ADDR;
        end
        default: next_r.st = SL_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r        <= '0;
      r.scl_s1 <= 1'b1;
      r.scl_s2 <= 1'b1;
      r.scl_d  <= 1'b1;
      r.sda_s1 <= 1'b1;
      r.sda_s2 <= 1'b1;
      r.sda_d  <= 1'b1;
      r.st     <= SL_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign sda_oe        = r.oe;
  assign link.rx_valid = r.rx_valid;
  assign link.rx_first = r.rx_first;
  assign link.rx_data  = r.shreg;
  assign link.tx_load  = r.tx_load;
endmodule : smbus_bit_slave

// >>> src/conv_sequencer.sv
// conversion timebase: rate divider, busy window, abort
`timescale 1ns/100ps
module conv_sequencer #(
  parameter int CONV_CYCLES   = 6000000,
  parameter int SLOW_PERIOD   = 800000000
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run_en,
  input  wire logic       oneshot,
  input  wire logic       abort,
  input  wire logic [3:0] rate_code,
  output logic            busy,
  output logic            done
);
  import smbus_temp_pkg::*;

  conv_regs_t  r, next_r;
  logic [31:0] period_len;
  logic        tick;

  always_comb begin
    period_len = 32'(SLOW_PERIOD) >> rate_code;
    tick       = run_en && (r.per == 32'h0);
    next_r      = r;
    next_r.done = 1'b0;
    if (!run_en || r.per >= period_len - 32'h1) next_r.per = 32'h0;
    else next_r.per = r.per + 32'h1;
    if (abort) begin
      // aborted sequence never raises done, so results stay untouched
      next_r.busy = 1'b0;
      next_r.cnt  = 32'h0;
    end else if (r.busy) begin
      if (r.cnt >= 32'(CONV_CYCLES) - 32'h1) begin
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
      end else begin
        next_r.cnt = r.cnt + 32'h1;
      end
    end else if (tick || oneshot) begin
      next_r.busy = 1'b1;
      next_r.cnt  = 32'h0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) r <= '0;
    else r <= next_r;
  end

  assign busy = r.busy;
  assign done = r.done;
endmodule : conv_sequencer

// >>> tb/smbus_host_model.sv
// host master model of the two-wire bus: start, stop, bit and byte frames
`timescale 1ns/100ps
`include "smbus_temp_defines.svh"
module smbus_host_model (
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  logic [6:0] addr     = `SLAVE_ADDR;
  logic       nak_seen = 1'b0;
  int         half     = 10;

  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // ----------------------------------------
  // bit level
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // also serves as repeated start from a low clock
  task automatic start_cond();
    tick(half / 2);
    sda_low <= 1'b0;
    tick(half);
    scl <= 1'b1;
    tick(half);
    sda_low <= 1'b1;
    tick(half);
    scl <= 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    tick(half / 2);
    sda_low <= 1'b1;
    tick(half / 2);
    scl <= 1'b1;
    tick(half);
    sda_low <= 1'b0;
    tick(half);
  endtask : stop_cond

  // sampled on a falling clk edge so the slave's register update has landed
  task automatic bit_io(input logic b, output logic r);
    tick(half / 2);
    sda_low <= !b;
    tick(half / 2);
    scl <= 1'b1;
    tick(half / 2);
    @(negedge clk);
    r = sda_line;
    tick(half / 2);
    scl <= 1'b0;
  endtask : bit_io

  task automatic send8(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    if (r !== 1'b0) nak_seen = 1'b1;
  endtask : send8

  task automatic recv8(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(1'b1, r);
  endtask : recv8

  // ----------------------------------------
  // frames
  // ----------------------------------------
  task automatic write_byte(input logic [7:0] cmd, input logic [7:0] data);
    start_cond();
    send8({addr, 1'b0});
    send8(cmd);
    send8(data);
    stop_cond();
  endtask : write_byte

  task automatic send_byte(input logic [7:0] cmd);
    start_cond();
    send8({addr, 1'b0});
    send8(cmd);
    stop_cond();
  endtask : send_byte

  task automatic read_byte(input logic [7:0] cmd, output logic [7:0] data);
    start_cond();
    send8({addr, 1'b0});
    send8(cmd);
    start_cond();
    send8({addr, 1'b1});
    recv8(data);
    stop_cond();
  endtask : read_byte

  // single master here, so nobody moves the pointer between frames
  task automatic recv_byte(output logic [7:0] data);
    start_cond();
    send8({addr, 1'b1});
    recv8(data);
    stop_cond();
  endtask : recv_byte
endmodule : smbus_host_model

// >>> tb/testbench.sv
// self-checking bench of the temperature readout block
`timescale 1ns/100ps
`include "smbus_temp_defines.svh"
module testbench;
  logic        clk;
  logic        rst;
  logic        standby_pin_n;
  logic        busy;
  logic        sda_out;
  logic        sda_oe;
  logic        scl;
  logic        sda_low;
  logic [10:0] local_temp_in;
  logic [10:0] remote_temp_in;
  wire         sda_line;
  logic [7:0]  rd;
  logic        busy_q = 1'b0;
  int          starts = 0;
  int          s0;
  int          error_cnt = 0;
  int          samples_checked = 0;

  // open drain with pull-up
  assign sda_line = !(sda_low || sda_oe);

  smbus_temp_readout_standby #(.CONV_CYCLES(20), .SLOW_PERIOD(4096)) u_smbus_temp_readout_standby (
    .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .standby_pin_n(standby_pin_n), .local_temp_in(local_temp_in), .remote_temp_in(remote_temp_in),
    .busy(busy));

  smbus_host_model u_smbus_host_model (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // counts conversion starts, so short sequences inside a frame are not missed
  always @(posedge clk) begin
    busy_q <= busy;
    if (busy === 1'b1 && busy_q === 1'b0) starts <= starts + 1;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rd_chk(input logic [7:0] cmd, input logic [7:0] exp);
    u_smbus_host_model.read_byte(cmd, rd);
    check(rd, exp);
  endtask : rd_chk

  task automatic rx_chk(input logic [7:0] exp);
    u_smbus_host_model.recv_byte(rd);
    check(rd, exp);
  endtask : rx_chk

  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (busy !== lvl && n < lim) begin
      @(negedge clk);
      n++;
    end
    check({7'h00, busy}, {7'h00, lvl});
  endtask : wait_busy

  task automatic set_temps(input logic [10:0] l, input logic [10:0] r);
    @(posedge clk);
    local_temp_in  <= l;
    remote_temp_in <= r;
  endtask : set_temps

  task automatic set_pin(input logic v);
    @(posedge clk);
    standby_pin_n <= v;
  endtask : set_pin

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    #(60000 * 20);
    error_cnt++;
    test_done();
  end

  initial begin
    rst            = 1'b1;
    standby_pin_n  = 1'b1;
    local_temp_in  = {8'h19, 3'b101};
    remote_temp_in = {8'he7, 3'b011};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rd_chk(`CMD_CONFIG_RD, 8'h20);
    rd_chk(`CMD_RATE_RD, 8'h08);
    check({7'h00, sda_out}, 8'h00);
    rd_chk(`CMD_LOCAL_MAIN, 8'h19);
    rd_chk(`CMD_REMOTE_MAIN, 8'he7);
    rd_chk(`CMD_LOCAL_FRAC, 8'h00);
    rd_chk(`CMD_REMOTE_FRAC, 8'h00);
    rd_chk(8'h05, 8'h00);
    // foreign address must be ignored
    u_smbus_host_model.addr = 7'h2b;
    u_smbus_host_model.write_byte(`CMD_CONFIG_WR, 8'h60);
    check({7'h00, u_smbus_host_model.nak_seen}, 8'h01);
    u_smbus_host_model.addr     = `SLAVE_ADDR;
    u_smbus_host_model.nak_seen = 1'b0;
    rd_chk(`CMD_CONFIG_RD, 8'h20);
    // slow rate gives fractions
    u_smbus_host_model.write_byte(`CMD_RATE_WR, 8'h06);
    set_temps({8'h7f, 3'b010}, {8'hc9, 3'b110});
    wait_busy(1'b1, 80);
    wait_busy(1'b0, 40);
    rd_chk(`CMD_RATE_RD, 8'h06);
    rd_chk(`CMD_REMOTE_FRAC, 8'hc0);
    rd_chk(`CMD_LOCAL_FRAC, 8'h40);
    rd_chk(`CMD_LOCAL_MAIN, 8'h7f);
    rd_chk(`CMD_REMOTE_MAIN, 8'hc9);
    // software standby, then one-shot
    u_smbus_host_model.write_byte(`CMD_CONFIG_WR, 8'h60);
    set_temps({8'h00, 3'b111}, {8'h80, 3'b001});
    s0 = starts;
    repeat (200) @(posedge clk);
    check(8'(starts - s0), 8'h00);
    u_smbus_host_model.half = 20;
    rd_chk(`CMD_LOCAL_MAIN, 8'h7f);
    u_smbus_host_model.half = 10;
    rx_chk(8'h7f);
    rd_chk(`CMD_STATUS, 8'h00);
    u_smbus_host_model.write_byte(`CMD_LOCAL_MAIN, 8'h55);
    rd_chk(`CMD_LOCAL_MAIN, 8'h7f);
    rd_chk(`CMD_CONFIG_RD, 8'h60);
    u_smbus_host_model.send_byte(`CMD_ONE_SHOT);
    repeat (40) @(posedge clk);
    check(8'(starts - s0), 8'h01);
    rd_chk(`CMD_LOCAL_MAIN, 8'h00);
    rd_chk(`CMD_REMOTE_FRAC, 8'h20);
    rx_chk(8'h20);
    // hardware standby beats one-shot and run mode
    set_temps({8'h19, 3'b101}, {8'he7, 3'b011});
    set_pin(1'b0);
    repeat (4) @(posedge clk);
    s0 = starts;
    u_smbus_host_model.send_byte(`CMD_ONE_SHOT);
    u_smbus_host_model.write_byte(`CMD_CONFIG_WR, 8'h20);
    repeat (100) @(posedge clk);
    check(8'(starts - s0), 8'h00);
    rd_chk(`CMD_LOCAL_MAIN, 8'h00);
    rd_chk(`CMD_CONFIG_RD, 8'h20);
    // abort mid-conversion keeps old results
    set_pin(1'b1);
    wait_busy(1'b1, 10);
    repeat (5) @(posedge clk);
    set_pin(1'b0);
    wait_busy(1'b0, 8);
    repeat (40) @(posedge clk);
    rd_chk(`CMD_LOCAL_MAIN, 8'h00);
    rd_chk(`CMD_REMOTE_MAIN, 8'h80);
    // leaving standby resumes autoconversion
    set_pin(1'b1);
    s0 = starts;
    repeat (100) @(posedge clk);
    check({7'h00, starts - s0 > 1}, 8'h01);
    rd_chk(`CMD_LOCAL_MAIN, 8'h19);
    rd_chk(`CMD_LOCAL_FRAC, 8'ha0);
    u_smbus_host_model.write_byte(`CMD_RATE_WR, 8'h08);
    repeat (100) @(posedge clk);
    rd_chk(`CMD_LOCAL_FRAC, 8'h00);
    // halt, then clear it with the pin high: run mode must come back at once
    u_smbus_host_model.write_byte(`CMD_CONFIG_WR, 8'h60);
    s0 = starts;
    repeat (40) @(posedge clk);
    check(8'(starts - s0), 8'h00);
    u_smbus_host_model.write_byte(`CMD_CONFIG_WR, 8'h20);
    check({7'h00, starts - s0 > 0}, 8'h01);
    check({7'h00, u_smbus_host_model.nak_seen}, 8'h00);
    test_done();
  end
endmodule : testbench
